// *** rtl/tsb_entry_check_map.svh ***
`ifndef TSB_ENTRY_CHECK_MAP_SVH
`define TSB_ENTRY_CHECK_MAP_SVH
// ****************************************************************
// Tag word fields
// ****************************************************************
`define TAG_SPACE_HI    63
`define TAG_SPACE_LO    48
`define TAG_RSVD_HI     47
`define TAG_RSVD_LO     42
`define TAG_VPT_HI      41
`define TAG_VPT_LO      0
`define VADDR_VPT_LO    22
// ****************************************************************
// Data word fields
// ****************************************************************
`define DAT_OK          63
`define DAT_NFO         62
`define DAT_OSH_HI      61
`define DAT_OSH_LO      56
`define DAT_RPN_HI      55
`define DAT_RPN_LO      13
`define DAT_SWAP        12
`define DAT_STRICT      11
`define DAT_PCACHE      10
`define DAT_VCACHE      9
`define DAT_KERNEL      8
`define DAT_FETCH_OK    7
`define DAT_STORE_OK    6
`define DAT_OSL_HI      5
`define DAT_OSL_LO      4
`define DAT_PSIZE_HI    3
`define DAT_PSIZE_LO    0
// ****************************************************************
// Page offsets, address widths, table geometry
// ****************************************************************
`define OFS_8K          6'd13
`define OFS_64K         6'd16
`define OFS_4M          6'd22
`define OFS_256M        6'd28
`define PA_WIDTH        7'd40
`define TBL_MIN_LOG2    6'd9
`define TBL_LINE_SHIFT  4
`define RESET_WORD      64'h0000_0000_0000_0000
`endif

// *** rtl/tsb_entry_check_pkg.sv ***
package tsb_entry_check_pkg;
   typedef enum logic [3:0] {
      PSIZE_8K   = 4'h0,
      PSIZE_64K  = 4'h1,
      PSIZE_4M   = 4'h3,
      PSIZE_256M = 4'h5
   } page_size_t;

   typedef enum logic [1:0] {
      ACC_LOAD     = 2'h0,
      ACC_STORE    = 2'h1,
      ACC_FETCH    = 2'h2,
      ACC_PREFETCH = 2'h3
   } access_kind_t;
endpackage : tsb_entry_check_pkg

// *** rtl/tsb_entry_check.sv ***
// Overview of operation
// - Tag bits 63:48 hold the 16-bit address space tag, compared at lookup.
// - Any nonzero tag bit 47:42 forces a mismatch.
// - Tag bits 41:0 compare with virtual address bits 63:22.
// - Entry translates only when data bit 63 is set.
// - Bit 62 set: only nofault-space loads translate; other data accesses trap.
// - Fetch from a page with bit 62 set raises the fetch trap.
// - Data bits 61:56 are free for software; readback returns zero.
// - Data bits 55:13 give real address bits 55:13.
// - Real address width is at least 40 bits; upper bits read zero.
// - Bit 12 flips data endianness; ignored by the instruction unit.
// - Bit 11 set makes nofault-space loads trap within the page.
// - Bit 11: noncacheable non-block accesses strongly ordered, stores unmerged.
// - Bit 11: software prefetch becomes a no-op.
// - Bits 10 and 9 pass unaltered to the cache subsystem.
// - Instruction unit reads virtual cacheable as zero.
// - Bit 8 set and unprivileged access raises the matching trap.
// - Bit 7 clear makes instruction fetch trap.
// - Stores are permitted only when bit 6 is set.
// - Data bits 5:4 are free for software; readback returns zero.
// - Page size codes 0,1,3,5 mean 8K, 64K, 4M, 256M; others reserved.
// - Table index is the low n page number bits, added to the base.
// - Table holds at least 512 lines of 16 bytes each.
// - 8K, 64K and 4M pages supported; 256M supported too.
`include "tsb_entry_check_map.svh"
module tsb_entry_check
   import tsb_entry_check_pkg::*;
(
   input  wire logic         clk_sys,          // Processor clock
   input  wire logic         rst_b,            // Async reset, active low
   input  wire logic         req_valid,        // Lookup request strobe
   input  wire access_kind_t req_kind,         // Access kind
   input  wire logic         req_itu,          // Entry is for fetch unit
   input  wire logic         req_nofault,      // Load via nofault space
   input  wire logic         req_block,        // Block load or store
   input  wire logic         privileged_state, // Current privilege
   input  wire logic [15:0]  req_space,        // Requesting space tag
   input  wire logic [63:0]  req_vaddr,        // Virtual address
   input  wire logic [63:0]  tag_word,         // Entry tag word
   input  wire logic [63:0]  data_word,        // Entry data word
   input  wire logic [63:0]  table_base,       // Table base address
   input  wire logic [2:0]   table_size,       // Log2 entries minus 9
   output logic              rsp_valid_reg,    // Answer strobe
   output logic              hit_reg,          // Entry usable
   output logic              size_bad_reg,     // Reserved size code
   output logic [63:0]       real_addr_reg,    // Translated address
   output logic              fetch_trap_reg,   // fetch_access_trap
   output logic              data_trap_reg,    // data_access_trap
   output logic              store_deny_reg,   // Write not permitted
   output logic              swap_order_reg,   // Invert endianness
   output logic              strict_order_reg, // Strongly ordered
   output logic              no_merge_reg,     // Do not merge store
   output logic              prefetch_nop_reg, // Prefetch as no-op
   output logic              phys_cache_reg,   // phys_cachable
   output logic              virt_cache_reg,   // virt_cachable
   output logic [63:0]       readback_reg,     // Data word as held
   output logic [63:0]       entry_addr_reg    // Table line address
);
   // ****************************************************************
   // Tag comparison
   // ****************************************************************
   logic        space_eq;
   logic        rsvd_zero;
   logic        vpt_eq;
   logic        entry_ok;
   logic        size_bad;
   logic        match;
   assign space_eq  =
      tag_word[`TAG_SPACE_HI:`TAG_SPACE_LO] == req_space;
   assign rsvd_zero =
      tag_word[`TAG_RSVD_HI:`TAG_RSVD_LO] == 6'h00;
   assign vpt_eq    = tag_word[`TAG_VPT_HI:`TAG_VPT_LO] ==
      req_vaddr[63:`VADDR_VPT_LO];
   assign entry_ok  = data_word[`DAT_OK];
   // Reserved size codes cannot translate: the page extent is unknown
   assign match     = entry_ok && rsvd_zero && space_eq && vpt_eq
                      && !size_bad;

   // ****************************************************************
   // Page size decode
   // ****************************************************************
   logic [3:0]  psize;
   logic [5:0]  ofs_bits;
   assign psize = data_word[`DAT_PSIZE_HI:`DAT_PSIZE_LO];
   assign ofs_bits =
      (psize == PSIZE_8K)   ? `OFS_8K   :
      (psize == PSIZE_64K)  ? `OFS_64K  :
      (psize == PSIZE_4M)   ? `OFS_4M   :
      (psize == PSIZE_256M) ? `OFS_256M : `OFS_8K;
   assign size_bad = !(psize == PSIZE_8K || psize == PSIZE_64K ||
                       psize == PSIZE_4M || psize == PSIZE_256M);

   // ****************************************************************
   // Real address forming
   // ****************************************************************
   logic [63:0] ofs_mask;
   logic [63:0] pa_mask;
   logic [63:0] rpn_word;
   logic [63:0] real_next;
   assign ofs_mask = ~(64'hFFFF_FFFF_FFFF_FFFF << ofs_bits);
   // Bits above the implemented width read as zero
   assign pa_mask  = ~(64'hFFFF_FFFF_FFFF_FFFF << `PA_WIDTH);
   assign rpn_word = {8'h00, data_word[`DAT_RPN_HI:`DAT_RPN_LO],
                      13'h0000};
   assign real_next = ((rpn_word & ~ofs_mask) |
                       (req_vaddr & ofs_mask)) & pa_mask;

   // ****************************************************************
   // Permission checks
   // ****************************************************************
   logic        is_fetch;
   logic        is_store;
   logic        is_load;
   logic        is_data;
   logic        nf_load;
   logic        nfo;
   logic        strict;
   logic        noncache;
   logic        priv_fault;
   logic        fetch_next;
   logic        data_next;
   assign is_fetch = req_kind == ACC_FETCH;
   assign is_store = req_kind == ACC_STORE;
   assign is_load  = req_kind == ACC_LOAD;
   assign is_data  = is_load || is_store;
   assign nf_load  = is_load && req_nofault;
   assign nfo      = data_word[`DAT_NFO];
   assign strict   = data_word[`DAT_STRICT];
   assign noncache = !data_word[`DAT_PCACHE] && !data_word[`DAT_VCACHE];
   assign priv_fault = data_word[`DAT_KERNEL] && !privileged_state;
   assign fetch_next = match && is_fetch &&
      (nfo || priv_fault || !data_word[`DAT_FETCH_OK]);
   assign data_next  = match && is_data &&
      ((nfo && !nf_load) ||
       (strict && nf_load) ||
       priv_fault);

   // ****************************************************************
   // Attributes for the load/store pipeline and caches
   // ****************************************************************
   logic        store_deny_next;
   logic        swap_next;
   logic        strict_next;
   logic        no_merge_next;
   logic        pf_nop_next;
   logic        vcache_next;
   logic [63:0] readback_next;
   assign store_deny_next = match && is_store &&
      !data_word[`DAT_STORE_OK];
   assign swap_next   = match && !req_itu && is_data &&
      data_word[`DAT_SWAP];
   assign strict_next = match && strict && noncache && is_data &&
      !req_block;
   assign no_merge_next = match && strict && noncache && is_store;
   // Hardware instruction prefetch arrives as a fetch and is unaffected
   assign pf_nop_next = match && strict &&
      req_kind == ACC_PREFETCH;
   assign vcache_next = data_word[`DAT_VCACHE] && !req_itu;
   always_comb begin
      readback_next = data_word;
      readback_next[`DAT_OSH_HI:`DAT_OSH_LO] = 6'h00;
      readback_next[`DAT_OSL_HI:`DAT_OSL_LO] = 2'h0;
      if (req_itu) begin
         readback_next[`DAT_VCACHE] = 1'b0;
      end
   end

   // ****************************************************************
   // Table line address
   // ****************************************************************
   logic [5:0]  tbl_log2;
   logic [63:0] idx_mask;
   logic [63:0] vpn;
   logic [63:0] entry_next;
   assign tbl_log2 = `TBL_MIN_LOG2 + {3'h0, table_size};
   assign idx_mask = ~(64'hFFFF_FFFF_FFFF_FFFF << tbl_log2);
   assign vpn      = {13'h0000, req_vaddr[63:13]};
   // Each line is an 8-byte tag then an 8-byte data word
   assign entry_next = table_base +
      ((vpn & idx_mask) << `TBL_LINE_SHIFT);

   // ****************************************************************
   // Output registers
   // ****************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rsp_valid_reg    <= 1'b0;
         hit_reg          <= 1'b0;
         size_bad_reg     <= 1'b0;
         real_addr_reg    <= `RESET_WORD;
         fetch_trap_reg   <= 1'b0;
         data_trap_reg    <= 1'b0;
         store_deny_reg   <= 1'b0;
         swap_order_reg   <= 1'b0;
         strict_order_reg <= 1'b0;
         no_merge_reg     <= 1'b0;
         prefetch_nop_reg <= 1'b0;
         phys_cache_reg   <= 1'b0;
         virt_cache_reg   <= 1'b0;
         readback_reg     <= `RESET_WORD;
         entry_addr_reg   <= `RESET_WORD;
      end else begin
         rsp_valid_reg    <= req_valid;
         hit_reg          <= req_valid && match;
         size_bad_reg     <= req_valid && size_bad;
         real_addr_reg    <= match ? real_next : `RESET_WORD;
         fetch_trap_reg   <= req_valid && fetch_next;
         data_trap_reg    <= req_valid && data_next;
         store_deny_reg   <= req_valid && store_deny_next;
         swap_order_reg   <= req_valid && swap_next;
         strict_order_reg <= req_valid && strict_next;
         no_merge_reg     <= req_valid && no_merge_next;
         prefetch_nop_reg <= req_valid && pf_nop_next;
         phys_cache_reg   <= data_word[`DAT_PCACHE];
         virt_cache_reg   <= vcache_next;
         readback_reg     <= readback_next;
         entry_addr_reg   <= entry_next;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_hit_space_match: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      hit_reg |-> $past(tag_word[63:48]) == $past(req_space))
      else $error("hit with unequal space tag");

   a_rsvd_tag_miss: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      req_valid && tag_word[47:42] != 6'h00 |=> !hit_reg)
      else $error("hit with reserved tag bits set");

   a_page_tag_match: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      hit_reg |-> $past(tag_word[41:0]) == $past(req_vaddr[63:22]))
      else $error("hit with unequal page tag");

   a_invalid_no_use: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      req_valid && !data_word[63] |=> !hit_reg && !fetch_trap_reg
         && !data_trap_reg && real_addr_reg == 64'h0)
      else $error("invalid entry produced a result");

   a_nfo_store_trap: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      req_valid && match && data_word[62] && req_kind == ACC_STORE
      |=> data_trap_reg)
      else $error("store to nofault-only page did not trap");

   a_nfo_fetch_trap: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      req_valid && match && data_word[62] && req_kind == ACC_FETCH
      |=> fetch_trap_reg && !data_trap_reg)
      else $error("fetch from nofault-only page did not trap");

   a_os_bits_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      readback_reg[61:56] == 6'h00 && readback_reg[5:4] == 2'h0)
      else $error("software bits visible on readback");

   a_real_page: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      hit_reg && $past(data_word[3:0]) == 4'h0 |->
      real_addr_reg[39:13] == $past(data_word[39:13])
      && real_addr_reg[63:40] == 24'h000000)
      else $error("real page number wrong");

   a_strict_nf_trap: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      req_valid && match && data_word[11] && req_kind == ACC_LOAD
      && req_nofault |=> data_trap_reg)
      else $error("nofault load to strict page did not trap");

   a_itu_vcache_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      req_itu |=> !virt_cache_reg && !readback_reg[9] && !swap_order_reg)
      else $error("instruction unit shows virt cacheable or swap");

   a_kernel_page_trap: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      req_valid && match && data_word[8] && !privileged_state
      && req_kind != ACC_PREFETCH |=> fetch_trap_reg || data_trap_reg)
      else $error("unprivileged access to kernel page did not trap");

   a_store_perm: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      store_deny_reg |-> $past(req_kind) == ACC_STORE
      && !$past(data_word[6]))
      else $error("store denial without cause");

   // The line register still holds its reset value at the first edge
   a_table_index: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      $past(rst_b) && $past(table_size) == 3'h0 |->
      entry_addr_reg == $past(table_base) +
      {51'h0, $past(req_vaddr[21:13]), 4'h0})
      else $error("table line address wrong for 512 entries");

   a_rsvd_size_miss: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      req_valid && data_word[3:0] == 4'h2 |=> size_bad_reg && !hit_reg)
      else $error("reserved page size code was not refused");
endmodule : tsb_entry_check

// *** verification/lsu_model.sv ***
module lsu_model (
   input  wire logic        clk_sys,   // Processor clock
   input  wire logic        rst_b,     // Async reset, active low
   input  wire logic        rsp_valid, // Answer strobe from the lookup
   input  wire logic        hit,       // Entry usable
   output logic [15:0]      rsp_count_reg, // Answers consumed
   output logic [15:0]      hit_count_reg  // Hits consumed
);
   timeunit 1ns;
   timeprecision 1ps;

   // The answer stands one cycle only, so it is taken on that very edge
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rsp_count_reg <= 16'h0000;
         hit_count_reg <= 16'h0000;
      end else if (rsp_valid) begin
         rsp_count_reg <= rsp_count_reg + 16'h0001;
         hit_count_reg <= hit_count_reg + {15'h0000, hit};
      end
   end
endmodule : lsu_model

// *** verification/tsb_entry_check_test.sv ***
module tsb_entry_check_test
   import tsb_entry_check_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Stimulus, expectations and checking
   // ****************************************************************
   localparam logic [15:0] SPACE = 16'h5A3C;
   localparam logic [63:0] VADDR = 64'h1234_5678_9ABC_DEF0;
   localparam logic [63:0] BASE  = 64'h0000_0040_0000_0000;
   localparam logic [63:0] D     = 64'h8000_00AB_CDEF_E000;
   localparam logic [63:0] F_NFO = 64'h4000_0000_0000_0000;
   localparam logic [63:0] F_SOFT = 64'h3F00_0000_0000_0030;
   localparam logic [63:0] TBAD [6] = '{64'h0000_0400_0000_0000,
      64'h0000_8000_0000_0000, 64'h0001_0000_0000_0000,
      64'h8000_0000_0000_0000, 64'h0000_0000_0000_0001,
      64'h0000_0200_0000_0000};
   logic clk_sys, rst_b, req_valid, req_itu, req_nofault, req_block;
   logic privileged_state, rsp_valid_reg, hit_reg, size_bad_reg;
   logic fetch_trap_reg, data_trap_reg, store_deny_reg, swap_order_reg;
   logic strict_order_reg, no_merge_reg, prefetch_nop_reg;
   logic phys_cache_reg, virt_cache_reg;
   access_kind_t req_kind;
   logic [15:0] req_space, rsp_count_reg, hit_count_reg;
   logic [63:0] req_vaddr, tag_word, data_word, table_base;
   logic [63:0] real_addr_reg, readback_reg, entry_addr_reg;
   logic [2:0]  table_size;
   int compares, miscompares, cycles, nreq, nhit;

   tsb_entry_check i_tsb_entry_check (.clk_sys(clk_sys), .rst_b(rst_b),
      .req_valid(req_valid), .req_kind(req_kind), .req_itu(req_itu),
      .req_nofault(req_nofault), .req_block(req_block),
      .privileged_state(privileged_state), .req_space(req_space),
      .req_vaddr(req_vaddr), .tag_word(tag_word), .data_word(data_word),
      .table_base(table_base), .table_size(table_size),
      .rsp_valid_reg(rsp_valid_reg), .hit_reg(hit_reg),
      .size_bad_reg(size_bad_reg), .real_addr_reg(real_addr_reg),
      .fetch_trap_reg(fetch_trap_reg), .data_trap_reg(data_trap_reg),
      .store_deny_reg(store_deny_reg), .swap_order_reg(swap_order_reg),
      .strict_order_reg(strict_order_reg), .no_merge_reg(no_merge_reg),
      .prefetch_nop_reg(prefetch_nop_reg),
      .phys_cache_reg(phys_cache_reg), .virt_cache_reg(virt_cache_reg),
      .readback_reg(readback_reg), .entry_addr_reg(entry_addr_reg));

   lsu_model i_lsu_model (.clk_sys(clk_sys), .rst_b(rst_b),
      .rsp_valid(rsp_valid_reg), .hit(hit_reg),
      .rsp_count_reg(rsp_count_reg), .hit_count_reg(hit_count_reg));

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   // Called at a falling edge; requests go back to back, and the answer to
   // this one is checked at the next falling edge, before the next one is driven
   task automatic run(input access_kind_t k, input logic itu, nf, blk, prv,
                      input logic [63:0] tx, input logic [63:0] d);
      logic [63:0] t, msk, ra;
      logic m, lg, ld, st, dacc, nc;
      logic [5:0] ofs;
      t = {SPACE, 6'h00, VADDR[63:22]} ^ tx;
      req_kind = k;
      req_itu = itu;
      req_nofault = nf;
      req_block = blk;
      privileged_state = prv;
      tag_word = t;
      data_word = d;
      req_valid = 1'b1;
      case (d[3:0])
         4'h0: ofs = 6'd13;
         4'h1: ofs = 6'd16;
         4'h3: ofs = 6'd22;
         4'h5: ofs = 6'd28;
         default: ofs = 6'd0;
      endcase
      lg = (ofs != 6'd0);
      m = d[63] && t[47:42] == 6'h00 && t[63:48] == SPACE
          && t[41:0] == VADDR[63:22] && lg;
      msk = (64'h1 << ofs) - 64'h1;
      ra = m ? (((d & ~msk) | (VADDR & msk)) & 64'h0000_00FF_FFFF_FFFF)
             : 64'h0;
      ld = (k == ACC_LOAD);
      st = (k == ACC_STORE);
      dacc = ld || st;
      nc = !d[10] && !d[9];
      nreq++;
      nhit += int'(m);
      @(negedge clk_sys);
      chk(rsp_valid_reg, 1'b1);
      chk(hit_reg, m);
      chk(size_bad_reg, !lg);
      chk(real_addr_reg, ra);
      chk(fetch_trap_reg, m && k == ACC_FETCH
          && (d[62] || !d[7] || (d[8] && !prv)));
      chk(data_trap_reg, m && dacc && ((d[62] && !(ld && nf))
          || (d[11] && ld && nf) || (d[8] && !prv)));
      chk(store_deny_reg, m && st && !d[6]);
      chk(phys_cache_reg, d[10]);
      chk(virt_cache_reg, d[9] && !itu);
      chk(readback_reg, d & ~(F_SOFT | (itu ? 64'h200 : 64'h0)));
      chk(entry_addr_reg, BASE + (((VADDR >> 13)
          & ((64'h1 << (9 + table_size)) - 64'h1)) << 4));
      chk(swap_order_reg, m && d[12] && dacc && !itu);
      chk(strict_order_reg, m && d[11] && nc && dacc && !blk);
      chk(no_merge_reg, m && d[11] && nc && st);
      chk(prefetch_nop_reg, m && d[11] && k == ACC_PREFETCH);
   endtask : run

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // A hang would otherwise hold the run open; 69 requests need far less
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         report_and_stop();
      end
   end

   initial begin
      rst_b = 1'b0;
      req_valid = 1'b0;
      req_kind = ACC_LOAD;
      req_itu = 1'b0;
      req_nofault = 1'b0;
      req_block = 1'b0;
      privileged_state = 1'b1;
      req_space = SPACE;
      req_vaddr = VADDR;
      tag_word = 64'h0;
      data_word = 64'h0;
      table_base = BASE;
      table_size = 3'h0;
      repeat (6) @(negedge clk_sys);
      rst_b = 1'b1;
      run(ACC_LOAD, 1'b0, 1'b0, 1'b0, 1'b1, 64'h0, D | 64'hC0);
      for (int i = 0; i < 16; i++)
         run(ACC_LOAD, 1'b0, 1'b0, 1'b0, 1'b1, 64'h0, D | 64'(i));
      for (int i = 0; i < 6; i++)
         run(ACC_LOAD, 1'b0, 1'b0, 1'b0, 1'b1, TBAD[i], D);
      run(ACC_LOAD, 1'b0, 1'b0, 1'b0, 1'b1, 64'h0, {1'b0, D[62:0]});
      for (int k = 0; k < 8; k++)
         run(access_kind_t'(k[1:0]), k[1:0] == 2'h2, k[2], 1'b0, 1'b1,
             64'h0, D | F_NFO | 64'hC0);
      for (int k = 0; k < 16; k++)
         run(access_kind_t'(k[1:0]), 1'b0, k[2], k[3], 1'b1,
             64'h0, D | 64'h8C0);
      run(ACC_STORE, 1'b0, 1'b0, 1'b0, 1'b1, 64'h0, D | 64'hCC0);
      for (int k = 0; k < 8; k++)
         run(access_kind_t'(k[1:0]), k[1:0] == 2'h2, 1'b0, 1'b0, k[2],
             64'h0, D | 64'h1C0);
      run(ACC_FETCH, 1'b1, 1'b0, 1'b0, 1'b1, 64'h0, D | 64'h40);
      run(ACC_STORE, 1'b0, 1'b0, 1'b0, 1'b1, 64'h0, D | 64'h80);
      run(ACC_LOAD, 1'b0, 1'b0, 1'b0, 1'b1, 64'h0,
          D | F_SOFT | 64'h16C0);
      run(ACC_FETCH, 1'b1, 1'b0, 1'b0, 1'b1, 64'h0,
          D | F_SOFT | 64'h16C0);
      for (int i = 0; i < 8; i++) begin
         table_size = 3'(i);
         run(ACC_LOAD, 1'b0, 1'b0, 1'b0, 1'b1, 64'h0, D);
      end
      req_valid = 1'b0;
      @(negedge clk_sys);
      chk(rsp_valid_reg, 1'b0);
      chk(64'(rsp_count_reg), 64'(nreq));
      chk(64'(hit_count_reg), 64'(nhit));
      report_and_stop();
   end
endmodule : tsb_entry_check_test
